/* dma_flow_params.svh */
// dma_flow_params.svh: widths, reset values and defaults of the peripheral flow block
// assumes: included by its bare name from the package file; design files see its macros through it
`ifndef DMA_FLOW_PARAMS_SVH
`define DMA_FLOW_PARAMS_SVH

`define DMA_LINE_W        4
`define DMA_LEN_W         8
`define DMA_NUM_LINES     16
`define DMA_BUF_DEPTH     16
`define DMA_CMP_W         16
`define DMA_SYNC_STAGES   3
`define DMA_LEN_ONE       8'h01
`define DMA_LEVEL_ZERO    16'h0000

`endif

/* dma_flow_pkg.sv */
// dma_flow_pkg.sv: types shared by the peripheral flow handshake logic
// assumes: dma_flow_params.svh is on the include path
`include "dma_flow_params.svh"

package dma_flow_pkg;

    // one peripheral's four request lines
    typedef struct packed {
        logic burst_request;
        logic single_request;
        logic last_burst_request;
        logic last_single_request;
    } req_bits_t;

    // one transfer handed to the bus master
    typedef struct packed {
        logic                   is_write;
        logic [`DMA_LINE_W-1:0] line;
        logic [`DMA_LEN_W-1:0]  length;
        logic                   last;
    } xfer_cmd_t;

    typedef enum logic [1:0] {
        FLOW_SRC_TO_MEM,
        FLOW_MEM_TO_DST,
        FLOW_P2P_SRC,
        FLOW_P2P_DST
    } flow_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUN,
        ST_BUSY,
        ST_DONE,
        ST_LOAD
    } engine_state_t;

endpackage

/* dma_req_sync.sv */
// dma_req_sync.sv: optional three-stage synchroniser for one line's request bits
// assumes: raw requests may come from another clock; select is static per descriptor
`timescale 1ns/1ps

module dma_req_sync
    import dma_flow_pkg::*;
(
    // clock and reset
    input  wire logic      clk,
    input  wire logic      reset_n,
    // control
    input  wire logic      sync_select,
    // request in and out
    input  wire req_bits_t raw,
    output req_bits_t      sampled
);

    req_bits_t stage1;
    req_bits_t stage2;
    req_bits_t stage3;
    req_bits_t stable;

    // a bit changes only once the second and third stages agree
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            stable <= '0;
        end
        else
        begin
            stage1 <= raw;
            stage2 <= stage1;
            stage3 <= stage2;
            stable <= (stage2 ^ stage3) & stable | ~(stage2 ^ stage3) & stage3;
        end
    end

    assign sampled = sync_select ? stable : raw;

endmodule

/* dma_peripheral_flow_handshake.sv */
// dma_peripheral_flow_handshake.sv: request handshake and flow engine of one channel
// assumes: an outside bus master performs each transfer command and pulses xfer_done
`timescale 1ns/1ps

module dma_peripheral_flow_handshake
    import dma_flow_pkg::*;
#(
    parameter int NUM_LINES = `DMA_NUM_LINES,
    parameter int BUF_DEPTH = `DMA_BUF_DEPTH
)
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    // peripheral request lines
    input  wire req_bits_t [NUM_LINES-1:0] line_request,
    input  wire logic [NUM_LINES-1:0]   request_sync_select,
    output logic [NUM_LINES-1:0]        request_clear,
    output logic [NUM_LINES-1:0]        terminal_count_flag,
    // channel set-up from the current descriptor
    input  wire logic                   channel_enable,
    input  wire flow_mode_t             flow_mode,
    input  wire logic [`DMA_LINE_W-1:0] src_line,
    input  wire logic [`DMA_LINE_W-1:0] dst_line,
    input  wire logic [`DMA_LEN_W-1:0]  burst_length,
    input  wire logic                   tc_irq_enable,
    // descriptor chaining
    output logic                        next_descriptor_request,
    input  wire logic                   next_descriptor_loaded,
    output logic                        tc_irq,
    // bus master command
    output logic                        xfer_start,
    output xfer_cmd_t                   xfer_cmd,
    input  wire logic                   xfer_done
);

    localparam int LVL_W = $clog2(BUF_DEPTH + 1);
    localparam int CW    = `DMA_CMP_W;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // =====================================================================
    // functions
    function automatic logic any_req(input req_bits_t r);
        any_req = r.burst_request | r.single_request | r.last_burst_request
                  | r.last_single_request;
    endfunction

    function automatic logic [`DMA_LEN_W-1:0] req_len(input req_bits_t r,
                                                      input logic [`DMA_LEN_W-1:0] b);
        req_len = (r.burst_request | r.last_burst_request) ? b : `DMA_LEN_ONE;
    endfunction

    function automatic logic is_last(input req_bits_t r);
        is_last = r.last_burst_request | r.last_single_request;
    endfunction

    // =====================================================================
    // request sampling
    req_bits_t [NUM_LINES-1:0] req;

    for (genvar g = 0; g < NUM_LINES; g++)
    begin : g_sync
        dma_req_sync u_sync (
            .clk(clk), .reset_n(reset_n), .sync_select(request_sync_select[g]),
            .raw(line_request[g]), .sampled(req[g]));
    end

    // =====================================================================
    // state
    engine_state_t          state;
    engine_state_t          next_state;
    logic [LVL_W-1:0]       level;
    logic                   src_done;

    // =====================================================================
    // decode
    wire req_bits_t             src_req   = req[src_line];
    wire req_bits_t             dst_req   = req[dst_line];
    wire logic                  src_free  = !request_clear[src_line];
    wire logic                  dst_free  = !request_clear[dst_line];
    wire logic [CW-1:0]         level_w   = CW'(level);
    wire logic [CW-1:0]         room_w    = CW'(BUF_DEPTH) - level_w;
    wire logic [CW-1:0]         burst_w   = CW'(burst_length);
    wire logic [`DMA_LEN_W-1:0] src_len   = req_len(src_req, burst_length);
    wire logic [`DMA_LEN_W-1:0] dst_len   = req_len(dst_req, burst_length);
    wire logic                  single_md = flow_mode < FLOW_P2P_SRC;
    wire logic [`DMA_LINE_W-1:0] flow_ln  = (flow_mode == FLOW_SRC_TO_MEM) ? src_line : dst_line;
    wire req_bits_t             flow_req  = req[flow_ln];
    wire logic                  flow_go   = any_req(flow_req) && !request_clear[flow_ln];
    wire logic [`DMA_LEN_W-1:0] flow_len  = req_len(flow_req, burst_length);

    // source flow: full burst write, drain write, read
    wire logic [`DMA_LEN_W-1:0] drain_len = (level_w < burst_w) ? `DMA_LEN_W'(level)
                                                                 : burst_length;
    wire logic ps_write  = dst_req.burst_request && dst_free
                           && (level_w >= burst_w || (src_done && level != '0));
    wire logic [`DMA_LEN_W-1:0] ps_wlen = src_done ? drain_len : burst_length;
    wire logic ps_read   = !src_done && any_req(src_req) && src_free
                           && room_w >= CW'(src_len);
    wire logic ps_finish = src_done && level == '0;

    // destination flow: write when enough data, else read source for it
    wire logic pd_need   = any_req(dst_req) && dst_free;
    wire logic pd_write  = pd_need && level_w >= CW'(dst_len);
    wire logic pd_read   = pd_need && level_w < CW'(dst_len) && src_free
                           && (src_req.burst_request || src_req.single_request)
                           && room_w >= CW'(src_len);

    // command chosen this cycle in the run state
    logic      issue;
    logic      finish;
    xfer_cmd_t next_cmd;

    always_comb
    begin
        issue    = 1'b0;
        finish   = 1'b0;
        next_cmd = '0;
        if (single_md)
        begin
            // one transfer per request, no length kept
            issue           = flow_go;
            next_cmd.is_write = flow_mode == FLOW_MEM_TO_DST;
            next_cmd.line   = flow_ln;
            next_cmd.length = flow_len;
            next_cmd.last   = is_last(flow_req);
        end
        else if (flow_mode == FLOW_P2P_SRC)
        begin
            finish = ps_finish;
            if (ps_write)
            begin
                issue           = 1'b1;
                next_cmd.is_write = 1'b1;
                next_cmd.line   = dst_line;
                next_cmd.length = ps_wlen;
                next_cmd.last   = src_done && level_w == CW'(ps_wlen);
            end
            else if (ps_read)
            begin
                issue           = 1'b1;
                next_cmd.line   = src_line;
                next_cmd.length = src_len;
                next_cmd.last   = is_last(src_req);
            end
        end
        else
        begin
            if (pd_write)
            begin
                issue           = 1'b1;
                next_cmd.is_write = 1'b1;
                next_cmd.line   = dst_line;
                next_cmd.length = dst_len;
                next_cmd.last   = is_last(dst_req);
            end
            else if (pd_read)
            begin
                issue           = 1'b1;
                next_cmd.line   = src_line;
                next_cmd.length = src_len;
            end
        end
    end

    wire logic busy_done = state == ST_BUSY && xfer_done;
    wire logic launch    = state == ST_RUN && next_state == ST_BUSY;
    wire logic desc_end  = busy_done && xfer_cmd.last
                           && !(flow_mode == FLOW_P2P_SRC && !xfer_cmd.is_write);

    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE: next_state = channel_enable ? ST_RUN : ST_IDLE;
            ST_RUN:
            begin
                if (!channel_enable)
                    next_state = ST_IDLE;
                else if (finish)
                    next_state = ST_DONE;
                else if (issue)
                    next_state = ST_BUSY;
            end
            ST_BUSY: next_state = !xfer_done ? ST_BUSY : desc_end ? ST_DONE : ST_RUN;
            ST_DONE: next_state = ST_LOAD;
            ST_LOAD: next_state = next_descriptor_loaded ? ST_RUN : ST_LOAD;
        endcase
    end

    // =====================================================================
    // engine registers and descriptor chaining pulses
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state                   <= ST_IDLE;
            xfer_start              <= 1'b0;
            xfer_cmd                <= '0;
            next_descriptor_request <= 1'b0;
            tc_irq                  <= 1'b0;
        end
        else
        begin
            state                   <= next_state;
            xfer_start              <= launch;
            next_descriptor_request <= state == ST_DONE;
            tc_irq                  <= state == ST_DONE && tc_irq_enable;
            if (launch)
                xfer_cmd <= next_cmd;
        end
    end

    // buffer level and source-finished flag
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            level    <= '0;
            src_done <= 1'b0;
        end
        else if (desc_end && flow_mode == FLOW_P2P_DST)
            level    <= '0;
        else if (busy_done && !single_md)
        begin
            if (xfer_cmd.is_write)
                level <= level - LVL_W'(xfer_cmd.length);
            else
                level <= level + LVL_W'(xfer_cmd.length);
            if (!xfer_cmd.is_write && xfer_cmd.last)
                src_done <= 1'b1;
        end
        else if (state == ST_LOAD && next_descriptor_loaded)
            src_done <= 1'b0;
    end

    // =====================================================================
    // per-line clear and terminal count
    for (genvar g = 0; g < NUM_LINES; g++)
    begin : g_line
        wire logic served = busy_done && xfer_cmd.line == `DMA_LINE_W'(g);
        always_ff @(posedge clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                request_clear[g]       <= 1'b0;
                terminal_count_flag[g] <= 1'b0;
            end
            else if (served)
            begin
                request_clear[g]       <= 1'b1;
                terminal_count_flag[g] <= xfer_cmd.last;
            end
            else if (request_clear[g] && !any_req(req[g]))
            begin
                request_clear[g]       <= 1'b0;
                terminal_count_flag[g] <= 1'b0;
            end
        end

        AST_CLEAR_HOLDS: assert property (
            request_clear[g] && any_req(req[g]) |=> request_clear[g])
            else $error("clear dropped while request still high");
        AST_CLEAR_DROPS: assert property (
            request_clear[g] && !any_req(req[g]) && !served |=> !request_clear[g])
            else $error("clear not dropped after request went low");
        AST_TC_WITH_CLEAR: assert property (
            terminal_count_flag[g] |-> request_clear[g])
            else $error("terminal count without clear");
    end

    // =====================================================================
    // checks
    sequence s_last_done;
        busy_done && desc_end;
    endsequence

    sequence s_chain;
        state == ST_DONE ##1 next_descriptor_request && state == ST_LOAD;
    endsequence

    AST_LAST_CHAINS: assert property (
        s_last_done |=> s_chain)
        else $error("last transfer did not end the descriptor");
    AST_IRQ_GATED: assert property (
        state == ST_DONE |=> tc_irq == $past(tc_irq_enable))
        else $error("interrupt not following its enable");
    AST_NO_READ_AFTER_LAST: assert property (
        xfer_start && !xfer_cmd.is_write && flow_mode == FLOW_P2P_SRC |-> !$past(src_done))
        else $error("source read after its last request");
    AST_ALL_DONE_FIRST: assert property (
        state == ST_DONE && flow_mode == FLOW_P2P_SRC |-> src_done && level == '0)
        else $error("descriptor ended with transfers outstanding");
    AST_READ_ROOM: assert property (
        launch && !next_cmd.is_write && !single_md |-> room_w >= CW'(next_cmd.length))
        else $error("source read without buffer room");
    AST_WRITE_DATA: assert property (
        launch && next_cmd.is_write && !single_md
        |-> level_w >= CW'(next_cmd.length) && next_cmd.length <= burst_length)
        else $error("destination write beyond buffered data");
    AST_DISCARD: assert property (
        s_last_done and flow_mode == FLOW_P2P_DST |=> level == '0)
        else $error("leftover source data not discarded");
    AST_DEMAND_READ: assert property (
        launch && flow_mode == FLOW_P2P_DST && !next_cmd.is_write |-> any_req(dst_req))
        else $error("source read without destination demand");

endmodule

/* periph_model.sv */
// periph_model.sv: behavioural peripherals that raise flow-control requests on any line
// assumes: the bench pulses go for one cycle with a line and a one-hot request kind
`timescale 1ns/1ps

module periph_model
    import dma_flow_pkg::*;
#(
    parameter int NUM_LINES = 16
)
(
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    // orders from the bench
    input  wire logic                      go,
    input  wire logic [3:0]                go_line,
    input  wire req_bits_t                 go_kind,
    input  wire logic [1:0]                lag,
    // handshake with the controller
    input  wire logic [NUM_LINES-1:0]      clear,
    output req_bits_t [NUM_LINES-1:0]      req
);
    // ==========================================
    // request hold and release
    logic [NUM_LINES-1:0] held;
    logic [1:0]           wait_cnt;

    always_comb
    begin
        for (int i = 0; i < NUM_LINES; i++)
            held[i] = |req[i];
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            req      <= '0;
            wait_cnt <= 2'h0;
        end
        else
        begin
            // a slow peripheral reacts to clear only after lag cycles
            wait_cnt <= (|(held & clear)) ? wait_cnt + 2'h1 : 2'h0;
            for (int i = 0; i < NUM_LINES; i++)
                if (held[i] && clear[i] && wait_cnt >= lag)
                    req[i] <= '0;
            // one kind at a time, kept until served, never over a high clear
            if (go && !held[go_line] && !clear[go_line])
                req[go_line] <= go_kind;
        end
    end
endmodule

/* testbench.sv */
// testbench.sv: self-checking bench of the peripheral flow handshake engine
// assumes: design files and periph_model.sv compiled first; bench plays the bus master
`timescale 1ns/1ps

module testbench;
    import dma_flow_pkg::*;

    // ==========================================
    // signals
    localparam int        NL   = 16;
    localparam int        BD   = 8;
    localparam req_bits_t K_B  = 4'h8;
    localparam req_bits_t K_S  = 4'h4;
    localparam req_bits_t K_LB = 4'h2;
    localparam req_bits_t K_LS = 4'h1;

    logic               clk = 1'b0;
    logic               reset_n = 1'b0;
    req_bits_t [NL-1:0] line_request;
    logic [NL-1:0]      sync_sel = '0;
    logic [NL-1:0]      request_clear;
    logic [NL-1:0]      terminal_count_flag;
    logic               channel_enable = 1'b0;
    flow_mode_t         flow_mode = FLOW_MEM_TO_DST;
    logic [3:0]         src_line = 4'h0;
    logic [3:0]         dst_line = 4'h6;
    logic [7:0]         burst_length = 8'h03;
    logic               irq_en = 1'b1;
    logic               nd_req;
    logic               nd_loaded = 1'b0;
    logic               tc_irq;
    logic               irq_seen = 1'b0;
    logic               xfer_start;
    xfer_cmd_t          xfer_cmd;
    xfer_cmd_t          cmd_q[$];
    logic               xfer_done = 1'b0;
    logic               go = 1'b0;
    logic [3:0]         go_line = 4'h0;
    req_bits_t          go_kind = '0;
    logic [1:0]         lag = 2'h0;
    int                 err_count = 0;
    int                 check_count = 0;
    int                 nd_count = 0;
    int                 descs = 0;
    integer             seed = 32'h6693_5bbc;

    always #10 clk = ~clk;

    always @(posedge clk)
    begin
        if (nd_req === 1'b1)
        begin
            nd_count++;
            irq_seen = tc_irq;
        end
        if (xfer_start === 1'b1)
            cmd_q.push_back(xfer_cmd);
    end

    dma_peripheral_flow_handshake #(.NUM_LINES(NL), .BUF_DEPTH(BD)) uut (
        .clk(clk), .reset_n(reset_n), .line_request(line_request),
        .request_sync_select(sync_sel), .request_clear(request_clear),
        .terminal_count_flag(terminal_count_flag), .channel_enable(channel_enable),
        .flow_mode(flow_mode), .src_line(src_line), .dst_line(dst_line),
        .burst_length(burst_length), .tc_irq_enable(irq_en),
        .next_descriptor_request(nd_req), .next_descriptor_loaded(nd_loaded),
        .tc_irq(tc_irq), .xfer_start(xfer_start), .xfer_cmd(xfer_cmd),
        .xfer_done(xfer_done)
    );

    periph_model #(.NUM_LINES(NL)) peer (
        .clk(clk), .reset_n(reset_n), .go(go), .go_line(go_line), .go_kind(go_kind),
        .lag(lag), .clear(request_clear), .req(line_request)
    );

    // ==========================================
    // tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic raise(input logic [3:0] line, input req_bits_t kind);
        @(posedge clk);
        #1;
        go = 1'b1;
        go_line = line;
        go_kind = kind;
        lag = 2'($random(seed));
        @(posedge clk);
        #1;
        go = 1'b0;
    endtask

    // expects one command, completes it and follows clear and flag to their drop
    task automatic xfer(input logic wr, input logic [3:0] line, input logic [7:0] len,
                        input logic tc);
        int        n;
        xfer_cmd_t got;
        n = 0;
        while (cmd_q.size() == 0 && n < 40)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        got = (cmd_q.size() > 0) ? cmd_q.pop_front() : '0;
        check("command", 32'({1'b1, wr, line, len, tc}),
              32'({n < 40, got.is_write, got.line, got.length, got.last}));
        repeat (1 + $unsigned($random(seed)) % 4) @(posedge clk);
        #1;
        xfer_done = 1'b1;
        @(posedge clk);
        #1;
        xfer_done = 1'b0;
        check("clear and flag", 32'({1'b1, tc}),
              32'({request_clear[line], terminal_count_flag[line]}));
        n = 0;
        while (request_clear[line] !== 1'b0 && n < 30)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check("clear drop", 32'h0000_0000,
              32'({request_clear[line], terminal_count_flag[line]}));
    endtask

    task automatic quiet(input int cycles);
        repeat (cycles) @(posedge clk);
        #1;
        check("no command", 32'h0000_0000, 32'(cmd_q.size()));
    endtask

    task automatic end_desc(input flow_mode_t m, input logic [3:0] s, input logic [3:0] d,
                            input logic [7:0] b);
        int n;
        n = 0;
        while (nd_count == descs && n < 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        descs++;
        check("next descriptor", 32'(descs), 32'(nd_count));
        check("tc irq", 32'(irq_en), 32'(irq_seen));
        flow_mode = m;
        src_line = s;
        dst_line = d;
        burst_length = b;
        irq_en = 1'($random(seed));
        nd_loaded = 1'b1;
        @(posedge clk);
        #1;
        nd_loaded = 1'b0;
    endtask

    // ==========================================
    // main sequence
    initial
    begin
        logic [3:0] ln;
        req_bits_t  kind;
        sync_sel = 16'($random(seed));
        repeat (6) @(posedge clk);
        #1;
        reset_n = 1'b1;
        channel_enable = 1'b1;
        // memory-side modes: random bursts and singles, then a last of either size
        for (int m = 0; m < 2; m++)
        begin
            ln = (m == 0) ? dst_line : src_line;
            repeat (1 + $unsigned($random(seed)) % 4)
            begin
                kind = ($random(seed) & 1) ? K_B : K_S;
                raise(ln, kind);
                xfer(m == 0, ln, (kind == K_B) ? burst_length : 8'h01, 1'b0);
            end
            kind = ($random(seed) & 1) ? K_LB : K_LS;
            raise(ln, kind);
            xfer(m == 0, ln, (kind == K_LB) ? burst_length : 8'h01, 1'b1);
            if (m == 0)
                end_desc(FLOW_SRC_TO_MEM, 4'($random(seed)), 4'h0,
                         8'(1 + $unsigned($random(seed)) % 8));
            else
                end_desc(FLOW_P2P_SRC, 4'h3, 4'hc, 8'h04);
        end
        // source flow: fill the buffer, stall a read, then drain after the last read
        raise(4'h3, K_B);
        xfer(1'b0, 4'h3, 8'h04, 1'b0);
        raise(4'hc, K_B);
        xfer(1'b1, 4'hc, 8'h04, 1'b0);
        repeat (2)
        begin
            raise(4'h3, K_B);
            xfer(1'b0, 4'h3, 8'h04, 1'b0);
        end
        raise(4'h3, K_S);
        quiet(12);
        raise(4'hc, K_B);
        xfer(1'b1, 4'hc, 8'h04, 1'b0);
        xfer(1'b0, 4'h3, 8'h01, 1'b0);
        raise(4'h3, K_LS);
        xfer(1'b0, 4'h3, 8'h01, 1'b1);
        raise(4'h3, K_S);
        quiet(12);
        check("early descriptor", 32'(descs), 32'(nd_count));
        raise(4'hc, K_B);
        xfer(1'b1, 4'hc, 8'h04, 1'b0);
        raise(4'hc, K_B);
        xfer(1'b1, 4'hc, 8'h02, 1'b1);
        end_desc(FLOW_P2P_DST, 4'h5, 4'ha, 8'h04);
        // destination flow: reads only on demand, leftovers discarded at the end
        raise(4'ha, K_S);
        raise(4'h5, K_B);
        xfer(1'b0, 4'h5, 8'h04, 1'b0);
        xfer(1'b1, 4'ha, 8'h01, 1'b0);
        raise(4'ha, K_LS);
        xfer(1'b1, 4'ha, 8'h01, 1'b1);
        end_desc(FLOW_P2P_DST, 4'h5, 4'ha, 8'h04);
        raise(4'ha, K_S);
        quiet(12);
        raise(4'h5, K_S);
        xfer(1'b0, 4'h5, 8'h01, 1'b0);
        xfer(1'b1, 4'ha, 8'h01, 1'b0);
        raise(4'ha, K_LB);
        raise(4'h5, K_B);
        xfer(1'b0, 4'h5, 8'h04, 1'b0);
        xfer(1'b1, 4'ha, 8'h04, 1'b1);
        end_desc(FLOW_MEM_TO_DST, 4'h0, 4'h1, 8'h01);
        give_verdict();
    end

    initial
    begin
        #(20 * 8000);
        err_count++;
        give_verdict();
    end
endmodule
